// ### logic/cca_top.sv
// cca_top: counter array time base, clock select, registers, watchdog
// assumes: pins arrive from the crossbar, timer0_ovf is a clk-domain pulse
`timescale 1ns/1ps
`include "cca_map.svh"
module cca_top #(
  parameter int NUM_MOD = `CCA_NUM_MOD
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata_q,
  input wire logic timer0_ovf,
  input wire logic ext_count_in,
  input wire logic ext_osc_in,
  input wire logic [NUM_MOD-1:0] ccm_pin_in,
  output logic [NUM_MOD-1:0] ccm_pin_out_q,
  output logic [NUM_MOD-1:0] ccm_pin_oe_q,
  output logic wdt_reset_q
);
  localparam int SW = NUM_MOD + 2;
  localparam int WD = `CCA_WD_IDX;

  if (NUM_MOD < `CCA_NUM_MOD || NUM_MOD > `CCA_MAX_MOD) begin : g_chk
    $error("cca_top: NUM_MOD must lie between 6 and 8");
  end

  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] prev_q;
  logic [SW-1:0] rise;
  logic [SW-1:0] fall;
  logic eci_rise;
  logic osc_rise;
  logic [3:0] div12_q;
  logic [1:0] div4_q;
  logic [2:0] div8_q;
  logic tick;
  logic tick_run;
  logic [3:0] ctrl_q;
  logic ovf_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic lock_q;
  logic cause_q;
  logic wd_active;
  logic [NUM_MOD-1:0] flag_q;
  logic [NUM_MOD-1:0] ev;
  logic [NUM_MOD-1:0][7:0] mode_q;
  logic [NUM_MOD-1:0][15:0] val;
  logic [7:0] rd_d;
  logic wr_ctrl;
  logic wr_wdctl;
  logic wr_svc;
  logic wr_cntl;
  logic wr_cnth;
  logic wr_flags;

  assign wr_ctrl = reg_we && (reg_addr == `CCA_CTRL);
  assign wr_wdctl = reg_we && (reg_addr == `CCA_WDCTL);
  assign wr_svc = reg_we && (reg_addr == `CCA_WDSVC);
  assign wr_cntl = reg_we && (reg_addr == `CCA_CNTL);
  assign wr_cnth = reg_we && (reg_addr == `CCA_CNTH);
  assign wr_flags = reg_we && (reg_addr == `CCA_FLAGS);

  // two-flop synchronisers for pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {ext_osc_in, ext_count_in, ccm_pin_in};
      sync2_q <= sync1_q;
    end
  end

  // edge detection on synchronised pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  assign eci_rise = rise[NUM_MOD];
  assign osc_rise = rise[NUM_MOD+1];

  // clock dividers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div12_q <= 4'h0;
      div4_q <= 2'h0;
      div8_q <= 3'h0;
    end else begin
      div12_q <= (div12_q == `CCA_DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
      div4_q <= div4_q + 2'h1;
      if (osc_rise) begin
        div8_q <= div8_q + 3'h1;
      end
    end
  end

  // counter clock select
  always_comb begin
    tick = 1'b0;
    case (ctrl_q[`CCA_CTRL_SEL_HI:`CCA_CTRL_SEL_LO])
      `CCA_SEL_DIV12: tick = (div12_q == `CCA_DIV12_LAST);
      `CCA_SEL_DIV4: tick = (div4_q == `CCA_DIV4_LAST);
      `CCA_SEL_T0: tick = timer0_ovf;
      `CCA_SEL_ECI: tick = eci_rise;
      `CCA_SEL_SYS: tick = 1'b1;
      `CCA_SEL_OSC8: tick = osc_rise && (div8_q == `CCA_DIV8_LAST);
      default: tick = 1'b0;
    endcase
  end

  assign tick_run = tick && ctrl_q[`CCA_CTRL_RUN];

  // control register, run bit cannot be cleared under the watchdog
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `CCA_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata[3:0];
      if (wd_active) begin
        ctrl_q[`CCA_CTRL_RUN] <= 1'b1;
      end
    end
  end

  // shared time base
  always_comb begin
    cnt_d = cnt_q;
    if (tick_run) begin
      cnt_d = cnt_q + 16'h0001;
    end
    if (wr_cntl) begin
      cnt_d[7:0] = reg_wdata;
    end
    if (wr_cnth) begin
      cnt_d[15:8] = reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // overflow flag, set beats clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else if (tick_run && cnt_q == 16'hffff) begin
      ovf_q <= 1'b1;
    end else if (wr_ctrl && !reg_wdata[`CCA_CTRL_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  // module event flags, write one clears, set beats clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~(wr_flags ? reg_wdata[NUM_MOD-1:0] : '0)) | ev;
    end
  end

  // watchdog lock, kept across system reset
  always_ff @(posedge clk) begin
    if (!por_rst_n) begin
      lock_q <= 1'b0;
    end else if (wr_wdctl && !reg_wdata[`CCA_WDCTL_ACT]) begin
      lock_q <= 1'b1;
    end
  end

  assign wd_active = !lock_q &&
    (mode_q[WD][`CCA_MODE_HI:`CCA_MODE_LO] == cca_pkg::CCA_WDT);

  // watchdog expiry request and its sticky cause bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdt_reset_q <= 1'b0;
    end else begin
      wdt_reset_q <= wd_active && ev[WD];
    end
  end

  always_ff @(posedge clk) begin
    if (!por_rst_n) begin
      cause_q <= 1'b0;
    end else if (wdt_reset_q) begin
      cause_q <= 1'b1;
    end else if (wr_wdctl && reg_wdata[`CCA_WDCTL_CAUSE]) begin
      cause_q <= 1'b0;
    end
  end

  // module mode registers, module five held while watchdog runs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int j = 0; j < NUM_MOD; j++) begin
        mode_q[j] <= (j == WD) ? `CCA_MODE_WD_RST : 8'h00;
      end
    end else begin
      for (int j = 0; j < NUM_MOD; j++) begin
        if (reg_we && reg_addr == 6'(`CCA_MOD_BASE + j * `CCA_MOD_STRIDE) &&
            !(j == WD && wd_active)) begin
          mode_q[j] <= reg_wdata;
        end
      end
    end
  end

  // capture/compare modules
  for (genvar i = 0; i < NUM_MOD; i++) begin : g_mod
    localparam logic [5:0] BASE = 6'(`CCA_MOD_BASE + i * `CCA_MOD_STRIDE);
    localparam bit IS_WD = (i == WD);
    cca_pkg::cca_mode_t mode_raw;
    cca_pkg::cca_mode_t mode_eff;
    logic [1:0] be;
    logic [15:0] wv;
    logic svc;

    assign mode_raw = cca_pkg::cca_mode_t'(mode_q[i][`CCA_MODE_HI:`CCA_MODE_LO]);
    assign mode_eff = (mode_raw == cca_pkg::CCA_WDT && (!IS_WD || lock_q)) ?
      cca_pkg::CCA_OFF : mode_raw;
    assign svc = IS_WD && wr_svc && wd_active;
    assign be = {reg_we && reg_addr == BASE + 6'(`CCA_MOD_VALH),
                 reg_we && reg_addr == BASE + 6'(`CCA_MOD_VALL)} | {svc, svc};
    assign wv = svc ? cnt_q + {reg_wdata, 8'h00} : {reg_wdata, reg_wdata};

    cca_ccm #(
      .RST_VAL(16'h0000)
    ) u_ccm (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick_run),
      .count(cnt_q),
      .count_next(cnt_d),
      .mode(mode_eff),
      .cap_rise(mode_q[i][`CCA_MODE_CAPR]),
      .cap_fall(mode_q[i][`CCA_MODE_CAPF]),
      .pwm_sel(mode_q[i][`CCA_MODE_PWM_HI:`CCA_MODE_PWM_LO]),
      .pin_rise(rise[i]),
      .pin_fall(fall[i]),
      .wr_be(be),
      .wr_val(wv),
      .val_q(val[i]),
      .out_q(ccm_pin_out_q[i]),
      .oe_q(ccm_pin_oe_q[i]),
      .event_q(ev[i])
    );
  end

  // register read mux
  always_comb begin
    rd_d = 8'h00;
    case (reg_addr)
      `CCA_CTRL: rd_d = {ovf_q, 3'h0, ctrl_q};
      `CCA_WDCTL: rd_d = {5'h00, cause_q, lock_q, wd_active};
      `CCA_CNTL: rd_d = cnt_q[7:0];
      `CCA_CNTH: rd_d = cnt_q[15:8];
      default: rd_d = 8'h00;
    endcase
    for (int k = 0; k < NUM_MOD; k++) begin
      if (reg_addr == `CCA_FLAGS) begin
        rd_d[k] = flag_q[k];
      end
      if (reg_addr == 6'(`CCA_MOD_BASE + k * `CCA_MOD_STRIDE)) begin
        rd_d = mode_q[k];
      end
      if (reg_addr == 6'(`CCA_MOD_BASE + k * `CCA_MOD_STRIDE + `CCA_MOD_VALL)) begin
        rd_d = val[k][7:0];
      end
      if (reg_addr == 6'(`CCA_MOD_BASE + k * `CCA_MOD_STRIDE + `CCA_MOD_VALH)) begin
        rd_d = val[k][15:8];
      end
    end
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_re ? rd_d : 8'h00;
    end
  end
endmodule

// ### logic/cca_map.svh
// cca_map.svh: register offsets, field positions, reset values, divider counts
// assumes: included by the counter array modules
// How it works
// - one shared 16-bit counter feeds six to eight modules
// - counter clock picked from six sources
// - modules capture, time, toggle, modulate, or divide
// - modulator widths of 8, 9, 10, 11, 16 bits
// - module five may serve as watchdog timer
// - module five runs as watchdog after reset
// - software locks watchdog off until power-on reset
// - unserviced watchdog expiry requests a system reset
// - module pins and count input reach crossbar only
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH
`define CCA_CNT_W 16
`define CCA_NUM_MOD 6
`define CCA_MAX_MOD 8
`define CCA_WD_IDX 5
`define CCA_AW 6
`define CCA_DW 8
`define CCA_CTRL 6'h00
`define CCA_WDCTL 6'h01
`define CCA_WDSVC 6'h02
`define CCA_CNTL 6'h04
`define CCA_CNTH 6'h05
`define CCA_FLAGS 6'h06
`define CCA_MOD_BASE 8
`define CCA_MOD_STRIDE 4
`define CCA_MOD_MODE 0
`define CCA_MOD_VALL 1
`define CCA_MOD_VALH 2
`define CCA_CTRL_RUN 0
`define CCA_CTRL_SEL_LO 1
`define CCA_CTRL_SEL_HI 3
`define CCA_CTRL_OVF 7
`define CCA_CTRL_RST 4'h1
`define CCA_WDCTL_ACT 0
`define CCA_WDCTL_LOCK 1
`define CCA_WDCTL_CAUSE 2
`define CCA_MODE_LO 0
`define CCA_MODE_HI 2
`define CCA_MODE_CAPR 3
`define CCA_MODE_CAPF 4
`define CCA_MODE_PWM_LO 5
`define CCA_MODE_PWM_HI 7
`define CCA_MODE_WD_RST 8'h06
`define CCA_SEL_DIV12 3'h0
`define CCA_SEL_DIV4 3'h1
`define CCA_SEL_T0 3'h2
`define CCA_SEL_ECI 3'h3
`define CCA_SEL_SYS 3'h4
`define CCA_SEL_OSC8 3'h5
`define CCA_DIV12_LAST 4'hb
`define CCA_DIV4_LAST 2'h3
`define CCA_DIV8_LAST 3'h7
`define CCA_PWM8 3'h0
`define CCA_PWM9 3'h1
`define CCA_PWM10 3'h2
`define CCA_PWM11 3'h3
`define CCA_PWM16 3'h4
`define CCA_MASK8 16'h00ff
`define CCA_MASK9 16'h01ff
`define CCA_MASK10 16'h03ff
`define CCA_MASK11 16'h07ff
`define CCA_MASK16 16'hffff
`endif

// ### logic/cca_pkg.sv
// cca_pkg: types of the counter array
// assumes: constants come from cca_map.svh
package cca_pkg;
  typedef enum logic [2:0] {
    CCA_OFF,
    CCA_CAPTURE,
    CCA_TIMER,
    CCA_HSO,
    CCA_PWM,
    CCA_FREQ,
    CCA_WDT
  } cca_mode_t;
endpackage

// ### logic/cca_ccm.sv
// cca_ccm: one capture/compare module of the counter array
// assumes: tick, count and edges come from the same clock
`timescale 1ns/1ps
`include "cca_map.svh"
module cca_ccm #(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [15:0] count,
  input wire logic [15:0] count_next,
  input wire cca_pkg::cca_mode_t mode,
  input wire logic cap_rise,
  input wire logic cap_fall,
  input wire logic [2:0] pwm_sel,
  input wire logic pin_rise,
  input wire logic pin_fall,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_val,
  output logic [15:0] val_q,
  output logic out_q,
  output logic oe_q,
  output logic event_q
);
  logic hit;
  logic hit_lo;
  logic cap;
  logic [15:0] mask;
  logic pwm_hi;

  assign hit = tick && (count_next == val_q);
  assign hit_lo = tick && (count_next[7:0] == val_q[7:0]);
  assign cap = (mode == cca_pkg::CCA_CAPTURE) && ((pin_rise && cap_rise) || (pin_fall && cap_fall));

  // pwm resolution mask
  always_comb begin
    mask = `CCA_MASK8;
    case (pwm_sel)
      `CCA_PWM9: mask = `CCA_MASK9;
      `CCA_PWM10: mask = `CCA_MASK10;
      `CCA_PWM11: mask = `CCA_MASK11;
      `CCA_PWM16: mask = `CCA_MASK16;
      default: mask = `CCA_MASK8;
    endcase
  end
  assign pwm_hi = (count & mask) < (val_q & mask);

  // compare / capture value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      val_q <= RST_VAL;
    end else if (wr_be != 2'b00) begin
      if (wr_be[0]) begin
        val_q[7:0] <= wr_val[7:0];
      end
      if (wr_be[1]) begin
        val_q[15:8] <= wr_val[15:8];
      end
    end else if (cap) begin
      val_q <= count;
    end else if (mode == cca_pkg::CCA_FREQ && hit_lo) begin
      val_q[7:0] <= val_q[7:0] + val_q[15:8];
    end
  end

  // module output pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= (mode == cca_pkg::CCA_HSO) || (mode == cca_pkg::CCA_PWM) ||
              (mode == cca_pkg::CCA_FREQ);
      unique case (mode)
        cca_pkg::CCA_HSO: out_q <= hit ? ~out_q : out_q;
        cca_pkg::CCA_PWM: out_q <= pwm_hi;
        cca_pkg::CCA_FREQ: out_q <= hit_lo ? ~out_q : out_q;
        cca_pkg::CCA_OFF, cca_pkg::CCA_CAPTURE, cca_pkg::CCA_TIMER, cca_pkg::CCA_WDT:
          out_q <= 1'b0;
        default: out_q <= 1'b0;
      endcase
    end
  end

  // one-cycle event pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_q <= 1'b0;
    end else begin
      unique case (mode)
        cca_pkg::CCA_CAPTURE: event_q <= cap;
        cca_pkg::CCA_TIMER, cca_pkg::CCA_HSO, cca_pkg::CCA_PWM: event_q <= hit;
        cca_pkg::CCA_FREQ: event_q <= hit_lo;
        cca_pkg::CCA_WDT: event_q <= hit;
        cca_pkg::CCA_OFF: event_q <= 1'b0;
        default: event_q <= 1'b0;
      endcase
    end
  end
endmodule

// ### verif/cca_pins_model.sv
// cca_pins_model: crossbar side of the counter array pins
// assumes: driven by bench task calls, system clock only
`timescale 1ns/1ps
module cca_pins_model (
  input wire logic clk,
  output logic timer0_ovf,
  output logic ext_count_in,
  output logic ext_osc_in,
  output logic [5:0] ccm_pin_in
);
  initial begin
    timer0_ovf = 1'b0;
    ext_count_in = 1'b0;
    ext_osc_in = 1'b0;
    ccm_pin_in = 6'h00;
  end
  // oscillator runs free, half period one clock
  always @(posedge clk) ext_osc_in <= ~ext_osc_in;
  task pulse_count(input int n);
    repeat (n) begin
      @(posedge clk) ext_count_in <= 1'b1;
      repeat (3) @(posedge clk);
      ext_count_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task pulse_t0(input int n);
    repeat (n) begin
      @(posedge clk) timer0_ovf <= 1'b1;
      @(posedge clk) timer0_ovf <= 1'b0;
      @(posedge clk);
    end
  endtask
  task set_pin(input int i, input logic v);
    @(posedge clk) ccm_pin_in[i] <= v;
  endtask
endmodule

// ### verif/cca_top_monitor.sv
// cca_top_monitor: port assertions for the counter array
// assumes: bound to cca_top, one clock, synchronous rst_n
`timescale 1ns/1ps
module cca_top_monitor #(
  parameter int NUM_MOD = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_rdata_q,
  input wire logic [NUM_MOD-1:0] ccm_pin_out_q,
  input wire logic [NUM_MOD-1:0] ccm_pin_oe_q,
  input wire logic wdt_reset_q
);
  logic lock_q, mod_wr_q, ctl_wr_q, rd_wd_q, rd_ctl_q;
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // lock survives system reset
  always_ff @(posedge clk) begin
    if (!por_rst_n) begin
      lock_q <= 1'b0;
    end else if (reg_we && reg_addr == 6'h01 && !reg_wdata[0]) begin
      lock_q <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mod_wr_q <= 1'b0;
      ctl_wr_q <= 1'b0;
    end else begin
      mod_wr_q <= mod_wr_q | (reg_we && reg_addr >= 6'h08);
      ctl_wr_q <= ctl_wr_q | (reg_we && reg_addr == 6'h00);
    end
  end
  always_ff @(posedge clk) begin
    rd_wd_q <= reg_re && reg_addr == 6'h01;
    rd_ctl_q <= reg_re && reg_addr == 6'h00 && !ctl_wr_q;
  end
  rd_idle_a: assert property (!$past(reg_re) |-> reg_rdata_q == 8'h00)
    else $error("read data outside read cycle");
  rst_quiet_a: assert property ($rose(rst_n) |-> !wdt_reset_q && ccm_pin_oe_q == '0
    && ccm_pin_out_q == '0) else $error("outputs not quiet after reset");
  wdt_pulse_a: assert property (wdt_reset_q |=> !wdt_reset_q)
    else $error("watchdog request longer than one cycle");
  wdt_early_a: assert property ($rose(rst_n) |-> !wdt_reset_q [*8])
    else $error("watchdog request right after reset");
  wd_state_a: assert property (rd_wd_q |-> reg_rdata_q[1:0] == {lock_q, !lock_q})
    else $error("watchdog state read wrong");
  lock_quiet_a: assert property (lock_q && $past(lock_q, 3) |-> !wdt_reset_q)
    else $error("watchdog request while locked off");
  pin_oe_a: assert property (!mod_wr_q |-> ccm_pin_oe_q == '0)
    else $error("pin driven without module setup");
  ctrl_rst_a: assert property (rd_ctl_q |-> reg_rdata_q[6:0] == 7'h01)
    else $error("control reset value wrong");
endmodule
bind cca_top cca_top_monitor #(.NUM_MOD(NUM_MOD)) mon_u (.clk(clk), .rst_n(rst_n),
  .por_rst_n(por_rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata_q(reg_rdata_q), .ccm_pin_out_q(ccm_pin_out_q),
  .ccm_pin_oe_q(ccm_pin_oe_q), .wdt_reset_q(wdt_reset_q));

// ### verif/cca_top_tb.sv
// cca_top_tb: scenario bench for the counter array
// assumes: pins model on the crossbar side, design under logic/
`timescale 1ns/1ps
module cca_top_tb;
  logic clk, rst_n, por_rst_n, reg_we, reg_re, wdt_reset_q;
  logic timer0_ovf, ext_count_in, ext_osc_in;
  logic [5:0] reg_addr, ccm_pin_in, ccm_pin_out_q, ccm_pin_oe_q;
  logic [7:0] reg_wdata, reg_rdata_q;
  int fails = 0;
  int check_count = 0;
  cca_top #(.NUM_MOD(6)) dut_u (.clk(clk), .rst_n(rst_n), .por_rst_n(por_rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata_q(reg_rdata_q), .timer0_ovf(timer0_ovf), .ext_count_in(ext_count_in),
    .ext_osc_in(ext_osc_in), .ccm_pin_in(ccm_pin_in), .ccm_pin_out_q(ccm_pin_out_q),
    .ccm_pin_oe_q(ccm_pin_oe_q), .wdt_reset_q(wdt_reset_q));
  cca_pins_model pins_u (.clk(clk), .timer0_ovf(timer0_ovf), .ext_count_in(ext_count_in),
    .ext_osc_in(ext_osc_in), .ccm_pin_in(ccm_pin_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task end_of_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task rdc(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    logic [7:0] d;
    rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d & m});
  endtask
  task wait_wdt(input int n, input logic e, input string s);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (wdt_reset_q === 1'b1) hit = 1'b1;
    end
    chk(s, {15'h0000, e}, {15'h0000, hit});
    if (e && !hit) end_of_test;
  endtask
  task do_reset(input logic p);
    @(posedge clk);
    rst_n <= 1'b0;
    por_rst_n <= !p;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    por_rst_n <= 1'b1;
  endtask
  task t_reset;
    rdc(6'h00, 8'hff, 8'h01, "ctrl");
    rdc(6'h01, 8'h07, 8'h01, "wdctl");
    rdc(6'h1c, 8'hff, 8'h06, "mode5");
    rdc(6'h08, 8'hff, 8'h00, "mode0");
    rdc(6'h03, 8'hff, 8'h00, "hole");
    wr(6'h00, 8'h00);
    rdc(6'h00, 8'h01, 8'h01, "run kept");
    $display("t_reset end");
  endtask
  task t_wrap;
    wr(6'h00, 8'h09);
    wr(6'h05, 8'hff);
    wr(6'h04, 8'hf0);
    wait_wdt(40, 1'b1, "expiry");
    rdc(6'h00, 8'h80, 8'h80, "ovf");
    rdc(6'h05, 8'hff, 8'h00, "cnth");
    rdc(6'h01, 8'h04, 8'h04, "cause");
    wr(6'h00, 8'h09);
    rdc(6'h00, 8'h80, 8'h00, "ovf clr");
    $display("t_wrap end");
  endtask
  task t_service;
    wr(6'h05, 8'hff);
    wr(6'h04, 8'hf0);
    wr(6'h02, 8'h10);
    rdc(6'h1e, 8'hff, 8'h0f, "svc valh");
    wait_wdt(40, 1'b0, "serviced");
    $display("t_service end");
  endtask
  task t_sources;
    logic [7:0] a, b, d;
    logic [2:0] sel [4];
    int cyc [4];
    int n [4];
    sel = '{3'h4, 3'h1, 3'h0, 3'h5};
    cyc = '{20, 40, 48, 64};
    n = '{20, 10, 4, 4};
    for (int i = 0; i < 4; i++) begin
      wr(6'h00, {4'h0, sel[i], 1'b1});
      rd(6'h04, a);
      repeat (cyc[i] - 2) @(posedge clk);
      rd(6'h04, b);
      d = b - a;
      chk("ticks", 16'(n[i]), {8'h00, d});
    end
    wr(6'h00, 8'h07);
    rd(6'h04, a);
    pins_u.pulse_count(5);
    rd(6'h04, b);
    d = b - a;
    chk("ext ticks", 16'h0005, {8'h00, d});
    wr(6'h00, 8'h05);
    rd(6'h04, a);
    pins_u.pulse_t0(3);
    rd(6'h04, b);
    d = b - a;
    chk("t0 ticks", 16'h0003, {8'h00, d});
    $display("t_sources end");
  endtask
  task t_modes;
    logic [2:0] m [3];
    logic e [3];
    m = '{3'h2, 3'h3, 3'h5};
    e = '{1'b0, 1'b1, 1'b1};
    wr(6'h00, 8'h09);
    wr(6'h06, 8'h3f);
    wr(6'h08, 8'h09);
    pins_u.set_pin(0, 1'b1);
    repeat (6) @(posedge clk);
    rdc(6'h06, 8'h01, 8'h01, "rise flag");
    wr(6'h06, 8'h01);
    pins_u.set_pin(0, 1'b0);
    repeat (6) @(posedge clk);
    rdc(6'h06, 8'h01, 8'h00, "fall ignored");
    chk("cap oe", 16'h0000, {15'h0000, ccm_pin_oe_q[0]});
    for (int i = 0; i < 3; i++) begin
      wr(6'h10, {5'h00, m[i]});
      repeat (3) @(posedge clk);
      chk("mode oe", {15'h0000, e[i]}, {15'h0000, ccm_pin_oe_q[2]});
    end
    $display("t_modes end");
  endtask
  task t_pwm;
    int cnt;
    wr(6'h0d, 8'h40);
    wr(6'h0e, 8'h00);
    for (int w = 0; w < 5; w++) begin
      if (w == 4) begin
        wr(6'h0e, 8'h90);
        wr(6'h0d, 8'h00);
        wr(6'h05, 8'h80);
      end
      wr(6'h0c, {w[2:0], 5'h04});
      repeat (4) @(posedge clk);
      cnt = 0;
      repeat (w == 4 ? 256 : 256 << w) begin
        @(posedge clk);
        if (ccm_pin_out_q[1] === 1'b1) cnt++;
      end
      chk("pwm high", 16'(w == 4 ? 256 : 64), 16'(cnt));
    end
    chk("pwm oe", 16'h0001, {15'h0000, ccm_pin_oe_q[1]});
    $display("t_pwm end");
  endtask
  task t_lock;
    wr(6'h01, 8'h00);
    rdc(6'h01, 8'h03, 8'h02, "locked");
    wr(6'h01, 8'h01);
    wr(6'h1c, 8'h06);
    rdc(6'h01, 8'h03, 8'h02, "stays off");
    do_reset(1'b0);
    rdc(6'h01, 8'h03, 8'h02, "off past reset");
    do_reset(1'b1);
    rdc(6'h01, 8'h03, 8'h01, "on after por");
    $display("t_lock end");
  endtask
  initial begin
    rst_n = 1'b0;
    por_rst_n = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    do_reset(1'b1);
    t_reset;
    t_wrap;
    t_service;
    t_sources;
    t_modes;
    t_pwm;
    t_lock;
    end_of_test;
  end
endmodule
